// file: verilog/sarpc_top.sv
// conversion cycle, serial result and power state control
`timescale 1ns/1ns
`default_nettype none
module sarpc_top #(
  parameter int RESULT_BITS = sarpc_pkg::RESULT_BITS
) (
  input  wire logic                   CLK,
  input  wire logic                   RESET_N,
  input  wire logic                   SELECT_N,
  input  wire logic                   SHIFT_CLOCK,
  input  wire logic                   COMPARATOR,
  output logic                        RESULT_OUT,
  output logic                        RESULT_OE,
  output logic                        ANALOG_ON,
  output logic                        DIGITAL_ON,
  output logic                        SAMPLING,
  output logic                        CONV_DONE,
  output logic [RESULT_BITS-1:0]      RESULT_WORD
);
  logic                         select_n_s;
  logic                         shift_clock_s;
  logic                         comparator_s;
  logic                         shift_clock_d_reg;
  logic                         fall_edge;
  logic [sarpc_pkg::CNT_W-1:0]  edge_cnt_reg;
  logic [RESULT_BITS-1:0]       result_reg;
  logic [RESULT_BITS-1:0]       trial_reg;
  logic [4:0]                   rep_idx_reg;
  sarpc_pkg::sarpc_state_type   state_reg;
  sarpc_pkg::sarpc_power_type   power_next;

  // pins cross in through two flops before any logic reads them
  sarpc_sync #(.INIT(1'b1)) u_sync_sel (
    .clk      (CLK),
    .reset_n  (RESET_N),
    .pin_in   (SELECT_N),
    .pin_sync (select_n_s)
  );
  // idle level of the shift clock is high, so no false edge after reset
  sarpc_sync #(.INIT(1'b1)) u_sync_sck (
    .clk      (CLK),
    .reset_n  (RESET_N),
    .pin_in   (SHIFT_CLOCK),
    .pin_sync (shift_clock_s)
  );
  sarpc_sync #(.INIT(1'b0)) u_sync_cmp (
    .clk      (CLK),
    .reset_n  (RESET_N),
    .pin_in   (COMPARATOR),
    .pin_sync (comparator_s)
  );

  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
      shift_clock_d_reg <= 1'b1;
    else
      shift_clock_d_reg <= shift_clock_s;
  end

  // edge detect on the synchronised copy only
  assign fall_edge = shift_clock_d_reg & ~shift_clock_s;

  // falling edge counter, cleared whenever select is high
  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
      edge_cnt_reg <= '0;
    else if (select_n_s)
      edge_cnt_reg <= '0;
    else if (fall_edge && state_reg != sarpc_pkg::SARPC_DONE)
      edge_cnt_reg <= edge_cnt_reg + 6'h01;
  end

  // cycle sequencer
  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
      state_reg <= sarpc_pkg::SARPC_IDLE;
    else if (select_n_s)
      state_reg <= sarpc_pkg::SARPC_IDLE;
    else
    begin
      case (state_reg)
        sarpc_pkg::SARPC_IDLE:
          state_reg <= sarpc_pkg::SARPC_SAMPLE;
        sarpc_pkg::SARPC_SAMPLE:
          if (fall_edge && edge_cnt_reg + 6'h01 == sarpc_pkg::SAMPLE_EDGES)
            state_reg <= sarpc_pkg::SARPC_NULL;
        sarpc_pkg::SARPC_NULL:
          if (fall_edge)
            state_reg <= sarpc_pkg::SARPC_MSB_FIRST;
        sarpc_pkg::SARPC_MSB_FIRST:
          if (fall_edge && edge_cnt_reg + 6'h01 == sarpc_pkg::LSB_EDGE + 6'h01)
            state_reg <= sarpc_pkg::SARPC_LSB_FIRST;
        sarpc_pkg::SARPC_LSB_FIRST:
          if (fall_edge && edge_cnt_reg + 6'h01 == sarpc_pkg::DONE_EDGE)
            state_reg <= sarpc_pkg::SARPC_DONE;
        sarpc_pkg::SARPC_DONE:
          state_reg <= sarpc_pkg::SARPC_DONE;
        default:
          state_reg <= sarpc_pkg::SARPC_IDLE;
      endcase
    end
  end

  // successive approximation: trial bit walks down, comparator keeps or drops it
  // code grows with input, all ones at full scale, no offset binary
  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      result_reg <= sarpc_pkg::ZERO_CODE;
      trial_reg  <= '0;
    end
    else if (select_n_s)
    begin
      result_reg <= sarpc_pkg::ZERO_CODE;
      trial_reg  <= '0;
    end
    else if (fall_edge && state_reg == sarpc_pkg::SARPC_NULL)
    begin
      result_reg <= {comparator_s, {(RESULT_BITS-1){1'b0}}};
      trial_reg  <= {1'b0, 1'b1, {(RESULT_BITS-2){1'b0}}};
    end
    else if (fall_edge && state_reg == sarpc_pkg::SARPC_MSB_FIRST && trial_reg != '0)
    begin
      result_reg <= comparator_s ? (result_reg | trial_reg) : result_reg;
      trial_reg  <= trial_reg >> 1;
    end
  end

  // index of bit shown in the lsb first phase
  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
      rep_idx_reg <= '0;
    else if (state_reg != sarpc_pkg::SARPC_LSB_FIRST)
      rep_idx_reg <= 5'h01;
    else if (fall_edge)
      rep_idx_reg <= rep_idx_reg + 5'h01;
  end

  // serial output: cleared while select is high, else updated only on a detected falling edge
  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      RESULT_OUT <= 1'b0;
      RESULT_OE  <= 1'b0;
    end
    else if (select_n_s)
    begin
      RESULT_OUT <= 1'b0;
      RESULT_OE  <= 1'b0;
    end
    else if (fall_edge)
    begin
      case (state_reg)
        sarpc_pkg::SARPC_SAMPLE:
        begin
          RESULT_OE  <= (edge_cnt_reg + 6'h01 == sarpc_pkg::SAMPLE_EDGES);
          RESULT_OUT <= 1'b0;
        end
        sarpc_pkg::SARPC_NULL:
        begin
          RESULT_OE  <= 1'b1;
          RESULT_OUT <= comparator_s;
        end
        sarpc_pkg::SARPC_MSB_FIRST:
        begin
          RESULT_OE  <= 1'b1;
          // last msb-first edge starts the lsb first repeat with bit one
          if (trial_reg == '0)
            RESULT_OUT <= result_reg[1];
          else
            RESULT_OUT <= comparator_s;
        end
        sarpc_pkg::SARPC_LSB_FIRST:
        begin
          RESULT_OE  <= (edge_cnt_reg + 6'h01 != sarpc_pkg::DONE_EDGE);
          RESULT_OUT <= (edge_cnt_reg + 6'h01 != sarpc_pkg::DONE_EDGE)
                        ? result_reg[rep_idx_reg[3:0] + 4'h1] : 1'b0;
        end
        default:
        begin
          RESULT_OE  <= 1'b0;
          RESULT_OUT <= 1'b0;
        end
      endcase
    end
  end

  // power states
  always_comb
  begin
    power_next.digital_on = ~select_n_s;
    power_next.sampling   = (state_reg == sarpc_pkg::SARPC_IDLE) ||
                            (state_reg == sarpc_pkg::SARPC_SAMPLE);
    // analog stays up until the falling edge after the last decision; done or aborted drops it
    power_next.analog_on  = ~select_n_s &&
                            (state_reg != sarpc_pkg::SARPC_DONE) &&
                            (state_reg != sarpc_pkg::SARPC_LSB_FIRST);
  end

  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      ANALOG_ON  <= 1'b0;
      DIGITAL_ON <= 1'b0;
      SAMPLING   <= 1'b0;
    end
    else
    begin
      ANALOG_ON  <= power_next.analog_on;
      DIGITAL_ON <= power_next.digital_on;
      SAMPLING   <= power_next.sampling & ~select_n_s;
    end
  end

  // completed word, published on the falling edge after the last decision
  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      CONV_DONE   <= 1'b0;
      RESULT_WORD <= sarpc_pkg::ZERO_CODE;
    end
    else
    begin
      CONV_DONE <= fall_edge && state_reg == sarpc_pkg::SARPC_MSB_FIRST && trial_reg == '0
                   && ~select_n_s;
      if (fall_edge && state_reg == sarpc_pkg::SARPC_MSB_FIRST && trial_reg == '0
          && ~select_n_s)
        RESULT_WORD <= result_reg;
    end
  end
endmodule
`default_nettype wire

// file: verilog/sarpc_pkg.sv
// shared constants and types for the converter cycle control block
`default_nettype none
package sarpc_pkg;
  localparam int RESULT_BITS     = 16;
  localparam int CNT_W           = 6;
  // falling edges of the shift clock that form the sampling phase
  localparam logic [5:0] SAMPLE_EDGES = 6'h05;
  // edge at which the low null bit ends and the msb appears
  localparam logic [5:0] NULL_EDGE    = 6'h06;
  // edge at which the lsb is driven (msb first stream ends)
  localparam logic [5:0] LSB_EDGE     = 6'h15;
  // edge at which the repeated msb ends and the output floats
  localparam logic [5:0] DONE_EDGE    = 6'h25;
  localparam logic [15:0] FULL_SCALE  = 16'hFFFF;
  localparam logic [15:0] ZERO_CODE   = 16'h0000;
  // nominal figures, for reference by the bench
  localparam int BIT_TIME_NS          = 416;
  localparam int CLK_PERIOD_NS        = 10;

  typedef enum logic [2:0] {
    SARPC_IDLE,
    SARPC_SAMPLE,
    SARPC_NULL,
    SARPC_MSB_FIRST,
    SARPC_LSB_FIRST,
    SARPC_DONE
  } sarpc_state_type;

  typedef struct packed {
    logic analog_on;
    logic digital_on;
    logic sampling;
  } sarpc_power_type;
endpackage
`default_nettype wire

// file: verilog/sarpc_sync.sv
// two flip-flop synchroniser for one pin
`timescale 1ns/1ns
`default_nettype none
module sarpc_sync #(
  parameter logic INIT = 1'b0
) (
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic pin_in,
  output logic      pin_sync
);
  logic meta_reg;

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      meta_reg <= INIT;
      pin_sync <= INIT;
    end
    else
    begin
      meta_reg <= pin_in;
      pin_sync <= meta_reg;
    end
  end
endmodule
`default_nettype wire

// file: verification/sarpc_properties.sv
// port checker for the conversion cycle control block
`timescale 1ns/1ns
`default_nettype none
module sarpc_chk #(
  parameter int RESULT_BITS = 16
) (
  input wire logic                   CLK,
  input wire logic                   RESET_N,
  input wire logic                   SELECT_N,
  input wire logic                   SHIFT_CLOCK,
  input wire logic                   RESULT_OUT,
  input wire logic                   RESULT_OE,
  input wire logic                   ANALOG_ON,
  input wire logic                   DIGITAL_ON,
  input wire logic                   CONV_DONE,
  input wire logic [RESULT_BITS-1:0] RESULT_WORD
);
  logic [6:0] sc_h;
  logic [2:0] dn_h;
  logic [3:0] sl_h;
  default clocking @(posedge CLK); endclocking
  default disable iff (!RESET_N);
  // pin history, since pin effects land a few cycles late
  always_ff @(posedge CLK or negedge RESET_N)
    if (!RESET_N)
    begin
      sc_h <= 7'h00;
      dn_h <= 3'h0;
      sl_h <= 4'hF;
    end
    else
    begin
      sc_h <= {sc_h[5:0], SHIFT_CLOCK};
      dn_h <= {dn_h[1:0], CONV_DONE};
      sl_h <= {sl_h[2:0], SELECT_N};
    end
  property p_oe_sel;
    SELECT_N [*5] |-> !RESULT_OE && !DIGITAL_ON && !ANALOG_ON;
  endproperty
  a_oe_sel: assert property (p_oe_sel) else $error("active while deselected");
  property p_dig_on;
    !SELECT_N [*5] |-> DIGITAL_ON;
  endproperty
  a_dig_on: assert property (p_dig_on) else $error("digital off while selected");
  // sync delay puts the output change two to six cycles after the pin fall
  property p_out_fall;
    RESULT_OE && $past(RESULT_OE) && $changed(RESULT_OUT) |-> |(~sc_h[5:1] & sc_h[6:2]);
  endproperty
  a_out_fall: assert property (p_out_fall) else $error("output moved off a fall");
  property p_done_an;
    CONV_DONE |-> ##[0:2] !ANALOG_ON;
  endproperty
  a_done_an: assert property (p_done_an) else $error("analog on after done");
  property p_word;
    $changed(RESULT_WORD) |-> CONV_DONE;
  endproperty
  a_word: assert property (p_word) else $error("word changed without done");
  property p_an_rise;
    $rose(ANALOG_ON) |-> !SELECT_N && !RESULT_OE;
  endproperty
  a_an_rise: assert property (p_an_rise) else $error("analog rose unselected");
  property p_an_fall;
    $fell(ANALOG_ON) |-> CONV_DONE || dn_h != 3'h0 || SELECT_N || sl_h != 4'h0;
  endproperty
  a_an_fall: assert property (p_an_fall) else $error("analog dropped early");
  property p_oe_null;
    $rose(RESULT_OE) |-> !RESULT_OUT && ANALOG_ON;
  endproperty
  a_oe_null: assert property (p_oe_null) else $error("null bit not low");
  c_done: cover property (CONV_DONE);
  c_null: cover property ($rose(RESULT_OE));
  c_abort: cover property ($fell(ANALOG_ON) && !CONV_DONE && dn_h == 3'h0);
endmodule
bind sarpc_top sarpc_chk #(.RESULT_BITS(RESULT_BITS)) chk_u (
  .CLK         (CLK),
  .RESET_N     (RESET_N),
  .SELECT_N    (SELECT_N),
  .SHIFT_CLOCK (SHIFT_CLOCK),
  .RESULT_OUT  (RESULT_OUT),
  .RESULT_OE   (RESULT_OE),
  .ANALOG_ON   (ANALOG_ON),
  .DIGITAL_ON  (DIGITAL_ON),
  .CONV_DONE   (CONV_DONE),
  .RESULT_WORD (RESULT_WORD)
);
`default_nettype wire

// file: verification/sarpc_host.sv
// host model: shift clock and comparator decisions
`timescale 1ns/1ns
`default_nettype none
module sarpc_host (
  input  wire logic        CLK,
  input  wire logic        go,
  input  wire logic [15:0] code,
  output logic             SHIFT_CLOCK = 1'b1,
  output logic             COMPARATOR = 1'b0,
  output logic [5:0]       nfall = 6'h00
);
  logic [2:0] div = 3'h0;
  // half period of 8 cycles keeps both phases above the 3 cycle minimum
  // pins move on the falling edge, well clear of the sampling edge
  always @(negedge CLK)
    if (!go)
    begin
      if (SHIFT_CLOCK)
        nfall <= 6'h00;
      SHIFT_CLOCK <= 1'b1;
      div <= 3'h0;
    end
    else
    begin
      div <= div + 3'h1;
      if (div == 3'h7)
      begin
        SHIFT_CLOCK <= ~SHIFT_CLOCK;
        if (SHIFT_CLOCK)
          nfall <= nfall + 6'h01;
        else if (nfall >= 6'h05 && nfall <= 6'h14)
          COMPARATOR <= code[6'h14 - nfall];
        else
          COMPARATOR <= ~COMPARATOR;
      end
    end
endmodule
`default_nettype wire

// file: verification/testbench.sv
// self-checking bench for the conversion cycle control block
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic        CLK = 1'b0;
  logic        RESET_N = 1'b0;
  logic        SELECT_N = 1'b1;
  logic        go = 1'b0;
  logic [15:0] code = 16'h0000;
  logic        SHIFT_CLOCK, COMPARATOR, RESULT_OUT, RESULT_OE, ANALOG_ON;
  logic        DIGITAL_ON, SAMPLING, CONV_DONE;
  logic [15:0] RESULT_WORD;
  logic [5:0]  nfall;
  logic [1:0]  cap [64];
  int          miscompares = 0;
  int          comparisons = 0;
  sarpc_top dut_u (
    .CLK         (CLK),
    .RESET_N     (RESET_N),
    .SELECT_N    (SELECT_N),
    .SHIFT_CLOCK (SHIFT_CLOCK),
    .COMPARATOR  (COMPARATOR),
    .RESULT_OUT  (RESULT_OUT),
    .RESULT_OE   (RESULT_OE),
    .ANALOG_ON   (ANALOG_ON),
    .DIGITAL_ON  (DIGITAL_ON),
    .SAMPLING    (SAMPLING),
    .CONV_DONE   (CONV_DONE),
    .RESULT_WORD (RESULT_WORD)
  );
  sarpc_host host_u (
    .CLK         (CLK),
    .go          (go),
    .code        (code),
    .SHIFT_CLOCK (SHIFT_CLOCK),
    .COMPARATOR  (COMPARATOR),
    .nfall       (nfall)
  );
  initial
  begin
    forever #5 CLK = ~CLK;
  end
  // host samples on the rise; output only counts while enabled
  always @(posedge SHIFT_CLOCK)
    cap[nfall] = {RESULT_OE, RESULT_OE & RESULT_OUT};
  task chk(input string nm, input logic [15:0] e, input logic [15:0] s);
    comparisons++;
    if (s !== e)
    begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask
  function automatic logic [1:0] exp_bit(input logic [15:0] c, input int k);
    if (k < 5 || k > 36)
      return 2'h0;
    if (k == 5)
      return 2'h2;
    return {1'b1, c[k < 22 ? 21 - k : k - 21]};
  endfunction
  task run(input logic [15:0] c, input logic [5:0] n, input logic [15:0] s);
    code = c;
    foreach (cap[k])
      cap[k] = 2'bxx;
    SELECT_N = 1'b0;
    repeat (4) @(negedge CLK);
    chk("start power", s, {ANALOG_ON, DIGITAL_ON, SAMPLING});
    go <= 1'b1;
    for (int i = 0; i < 900 && nfall !== n; i++)
      @(negedge CLK);
    if (nfall !== n)
    begin
      miscompares++;
      results();
    end
    // let the low phase run out so the last bit is sampled after it settles
    repeat (8) @(negedge CLK);
    go <= 1'b0;
    repeat (12) @(negedge CLK);
  endtask
  task full(input logic [15:0] c);
    run(c, 6'h28, 16'h7);
    for (int k = 1; k <= 40; k++)
      chk("serial", exp_bit(c, k), cap[k]);
    chk("word", c, RESULT_WORD);
    chk("power", 16'h2, {ANALOG_ON, DIGITAL_ON, SAMPLING});
  endtask
  task idle;
    SELECT_N = 1'b1;
    repeat (6) @(negedge CLK);
    chk("off", 16'h0, {RESULT_OE, ANALOG_ON, DIGITAL_ON, SAMPLING});
  endtask
  task blocked(input logic [15:0] w);
    run(16'h1234, 6'h0A, 16'h2);
    for (int k = 1; k <= 10; k++)
      chk("ignored", 16'h0, cap[k]);
    chk("word", w, RESULT_WORD);
  endtask
  task abort(input logic [15:0] c, input logic [15:0] w);
    run(c, 6'h13, 16'h7);
    for (int k = 1; k <= 19; k++)
      chk("short", exp_bit(c, k), cap[k]);
    idle();
    chk("word", w, RESULT_WORD);
  endtask
  task results;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial
  begin
    repeat (3) @(negedge CLK);
    RESET_N = 1'b1;
    repeat (3) @(negedge CLK);
    chk("reset", 16'h0, {RESULT_OE, RESULT_OUT, ANALOG_ON, DIGITAL_ON, SAMPLING, CONV_DONE});
    chk("reset word", 16'h0, RESULT_WORD);
    full(16'h0000);
    idle();
    full(16'hFFFF);
    idle();
    full(16'hA5C3);
    blocked(16'hA5C3);
    idle();
    abort(16'h5A3C, 16'hA5C3);
    full(16'h8001);
    idle();
    results();
  end
endmodule
`default_nettype wire
